// [sim/gdfp_fet_model.sv]
// Behavioural bridge of six MOSFETs: cutoff comparators and fault line pull-up
`timescale 1ns/10ps
module gdfp_fet_model
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic [2:0] i_gate_hi,
   input wire logic [2:0] i_gate_lo,
   input wire logic [7:0] i_off_dly,
   input wire logic i_fault_oe,
   output logic [5:0] o_vgs_off,
   output logic o_fault_wire
);
   logic [7:0] off_cnt_q [6];
   logic [5:0] gate;
   assign gate = {i_gate_lo, i_gate_hi};
   // External pull-up resistor on the open-drain line
   assign o_fault_wire = !i_fault_oe;

   // Gate charge drains slowly, so cutoff shows only after the chosen delay
   always_ff @(posedge i_mclk or negedge i_rstn)
      for (int k = 0; k < 6; k++)
         if (!i_rstn)
            off_cnt_q[k] <= 8'hff;
         else if (gate[k])
            off_cnt_q[k] <= 8'h0;
         else if (off_cnt_q[k] != 8'hff)
            off_cnt_q[k] <= off_cnt_q[k] + 8'h1;

   always_comb
      for (int k = 0; k < 6; k++)
         o_vgs_off[k] = !gate[k] && off_cnt_q[k] >= i_off_dly;
endmodule

// [sim/gdfp_props.sv]
// Concurrent checks on the ports of the fault protection block
`timescale 1ns/10ps
module gdfp_props
#(
   parameter int WARN_N = 4,
   parameter int FAULT_N = 4,
   parameter int P_PULSE_CYC = 8
)
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [gdfp_pkg::ADR_W-1:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   input wire logic o_wb_ack,
   input wire logic i_gate_en,
   input wire logic [2:0] i_gate_cmd_hi,
   input wire logic [2:0] i_gate_cmd_lo,
   input wire logic [5:0] i_vgs_off,
   input wire logic [WARN_N-1:0] i_warn_cond,
   input wire logic [FAULT_N-1:0] i_fault_cond,
   input wire logic i_vreg_in_range,
   input wire logic i_regulator_undervoltage,
   input wire logic i_wdog_fault,
   input wire logic o_fault_out_n_oe,
   input wire logic o_power_good_out,
   input wire logic [2:0] o_gate_hi,
   input wire logic [2:0] o_gate_lo,
   input wire logic [4:0] o_drain_source_threshold
);
   import gdfp_pkg::*;
   logic take, ocp_wr, clr_wr, pg_seen_q;
   logic [15:0] hold_cnt_q, pg_low_q;
   logic [4:0] thr_exp_q;
   assign take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];
   assign ocp_wr = take && i_wb_adr[5:2] == REG_OCP;
   assign clr_wr = take && i_wb_adr[5:2] == REG_CONTROL && i_wb_dat[CT_CLEAR_BIT];

   // Unbroken cycles of the phase A high-side turn-on condition
   always_ff @(posedge i_mclk or negedge i_rstn)
      if (!i_rstn)
         hold_cnt_q <= 16'h0;
      else if (i_gate_cmd_hi[0] && !i_gate_cmd_lo[0] && i_vgs_off[3])
         hold_cnt_q <= hold_cnt_q + 16'h1;
      else
         hold_cnt_q <= 16'h0;

   // First rise after reset is exempt: the sequencer starts in recheck
   always_ff @(posedge i_mclk or negedge i_rstn)
      if (!i_rstn)
      begin
         pg_low_q <= 16'h0;
         pg_seen_q <= 1'b0;
      end
      else
      begin
         pg_low_q <= o_power_good_out ? 16'h0 : pg_low_q + 16'h1;
         pg_seen_q <= pg_seen_q | o_power_good_out;
      end

   always_ff @(posedge i_mclk or negedge i_rstn)
      if (!i_rstn)
         thr_exp_q <= RST_THR;
      else if (ocp_wr)
         thr_exp_q <= i_wb_dat[OC_THR_LSB+:5];

   // ********
   // Properties
   // ********
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_fault_kept;
      (i_fault_cond != '0 && i_gate_en && !clr_wr) ##1 (i_gate_en && !clr_wr) [*7];
   endsequence
   property p_fault_pin;
      i_fault_cond != '0 |-> ##[1:2] o_fault_out_n_oe;
   endproperty
   property p_fault_gates;
      i_fault_cond != '0 |-> ##[1:3] (o_gate_hi == 3'h0 && o_gate_lo == 3'h0);
   endproperty
   property p_latched;
      s_fault_kept |=> o_fault_out_n_oe;
   endproperty
   property p_clear;
      clr_wr && i_fault_cond == '0 && i_warn_cond == '0 |-> ##3 !o_fault_out_n_oe;
   endproperty
   property p_no_shoot;
      (o_gate_hi & o_gate_lo) == 3'h0;
   endproperty
   property p_dead;
      $rose(o_gate_hi[0]) |-> $past(hold_cnt_q) >= 16'd4;
   endproperty
   property p_thr;
      ocp_wr |-> ##2 o_drain_source_threshold == thr_exp_q;
   endproperty
   property p_pg_len;
      $rose(o_power_good_out) && pg_seen_q |-> $past(pg_low_q) >= P_PULSE_CYC;
   endproperty
   property p_pg_recover;
      $rose(o_power_good_out) |-> $past(i_vreg_in_range && !i_regulator_undervoltage);
   endproperty
   property p_pg_src;
      i_wdog_fault || i_regulator_undervoltage |-> ##[1:3] !o_power_good_out;
   endproperty

   a_fault_pin: assert property (p_fault_pin)
      else $error("fault pin not pulled low after a fault");
   a_fault_gates: assert property (p_fault_gates)
      else $error("gates still driven during a fault");
   a_latched: assert property (p_latched)
      else $error("fault released without recovery");
   a_clear: assert property (p_clear)
      else $error("fault pin kept low after clear");
   a_no_shoot: assert property (p_no_shoot)
      else $error("both gates of one phase on");
   a_dead: assert property (p_dead)
      else $error("high gate on before dead time");
   a_thr: assert property (p_thr)
      else $error("threshold output not updated");
   a_pg_len: assert property (p_pg_len)
      else $error("power good low phase too short");
   a_pg_recover: assert property (p_pg_recover)
      else $error("power good raised while regulator bad");
   a_pg_src: assert property (p_pg_src)
      else $error("watchdog or undervoltage not on power good");
endmodule

// [sim/test_gate_driver_fault_protection.sv]
// Self-checking bench for the gate driver fault protection block
`timescale 1ns/10ps
module test_gate_driver_fault_protection;
   import gdfp_pkg::*;
   localparam int PULSE = 8;
   logic i_mclk = 1'b0, i_rstn = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
   logic i_gate_en = 1'b1, i_vreg_in_range = 1'b1, i_regulator_undervoltage = 1'b0;
   logic i_wdog_fault = 1'b0, o_wb_ack, o_fault_out_n_oe, o_power_good_out, fault_wire;
   logic [7:0] i_wb_adr = 8'h0, off_dly = 8'h0;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd, rnd = 32'ha064;
   logic [2:0] cmd_hi = 3'h0, cmd_lo = 3'h1, o_gate_hi, o_gate_lo;
   logic [5:0] vgs_off, oc_trip = 6'h0;
   logic [3:0] warn = 4'h0, fault = 4'h0, temp = 4'h0;
   logic [4:0] o_drain_source_threshold;
   logic o_fault_out_n;
   int n_errors = 0, checks = 0, n, lo_b, hi_cnt, edges, w, f;
   int dsel[3] = '{7, 2, 0};
   int ddly[3] = '{20, 5, 0};
   int pg_len[3] = '{16, 3, 3};
   logic [2:0] md[3] = '{OCM_LATCH, OCM_REPORT, 3'h5};

   always #5 i_mclk = ~i_mclk;

   gdfp_top #(.P_PULSE_CYC(PULSE)) DUT
   (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'b1), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(4'hf),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_gate_en(i_gate_en), .i_gate_cmd_hi(cmd_hi),
      .i_gate_cmd_lo(cmd_lo), .i_vgs_off(vgs_off), .i_oc_trip(oc_trip), .i_warn_cond(warn),
      .i_fault_cond(fault), .i_temperature_flag(temp), .i_vreg_in_range(i_vreg_in_range),
      .i_regulator_undervoltage(i_regulator_undervoltage), .i_wdog_fault(i_wdog_fault),
      .i_fault_out_n(fault_wire), .o_fault_out_n(o_fault_out_n),
      .o_fault_out_n_oe(o_fault_out_n_oe),
      .o_power_good_out(o_power_good_out), .o_gate_hi(o_gate_hi), .o_gate_lo(o_gate_lo),
      .o_drain_source_threshold(o_drain_source_threshold)
   );

   gdfp_fet_model u_fet
   (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_gate_hi(o_gate_hi), .i_gate_lo(o_gate_lo),
      .i_off_dly(off_dly), .i_fault_oe(o_fault_out_n_oe), .o_vgs_off(vgs_off),
      .o_fault_wire(fault_wire)
   );

   // ********
   // Helpers
   // ********
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge i_mclk);
   endtask

   // Single classic cycle; held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] wd);
      @(posedge i_mclk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= {2'h0, idx, 2'h0};
      i_wb_dat <= wd;
      @(posedge i_mclk);
      while (o_wb_ack !== 1'b1)
         @(posedge i_mclk);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask

   task automatic watch(input int c);
      logic prev;
      prev = o_fault_out_n_oe;
      hi_cnt = 0;
      edges = 0;
      repeat (c)
      begin
         @(posedge i_mclk);
         hi_cnt += (o_fault_out_n_oe === 1'b1);
         edges += (o_fault_out_n_oe !== prev);
         prev = o_fault_out_n_oe;
      end
   endtask

   task automatic print_verdict;
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      tick(20000);
      n_errors++;
      print_verdict();
   end

   // ********
   // Scenarios
   // ********
   initial
   begin
      tick(8);
      i_rstn <= 1'b1;
      wb(0, REG_TIMING, 0);
      check(rd, 32'h5);
      wb(0, REG_OCP, 0);
      check(rd, {24'h0, RST_THR, 3'h0});
      wb(0, 4'h3, 0);
      check(rd, 0);
      check(o_power_good_out, 1);
      for (int i = 0; i < 3; i++)
      begin
         wb(1, REG_TIMING, dsel[i] << 4);
         off_dly <= ddly[i];
         cmd_lo <= 3'h1;
         cmd_hi <= 3'h0;
         tick(60);
         cmd_lo <= 3'h0;
         cmd_hi <= 3'h1;
         n = 0;
         while (o_gate_hi[0] !== 1'b1 && n < 200)
         begin
            tick(1);
            n++;
         end
         lo_b = ddly[i] + (dsel[i] + 1) * 4;
         check(n >= lo_b && n <= lo_b + 8, 1);
      end
      cmd_hi <= 3'h0;
      tick(10);
      cmd_hi <= 3'h1;
      oc_trip <= 6'h1;
      tick(110);
      oc_trip <= 6'h0;
      wb(0, REG_ERRTYPE, 0);
      check(rd[5:0], 0);
      for (int m = 0; m < 3; m++)
      begin
         rnd = lfsr(rnd);
         wb(1, REG_OCP, {rnd[4:0], md[m]});
         tick(2);
         check(o_drain_source_threshold, rnd[4:0]);
         oc_trip <= 6'h1;
         tick(50);
         oc_trip <= 6'h0;
         wb(0, REG_ERRTYPE, 0);
         check(rd[5:0], 0);
         oc_trip <= 6'h1;
         watch(150);
         oc_trip <= 6'h0;
         check(hi_cnt > 0, m < 2);
         check(o_gate_hi, (m == 0) ? 3'h0 : 3'h1);
         wb(0, REG_ERRTYPE, 0);
         check(rd[6:0], (m == 0) ? 7'h41 : (m == 1) ? 7'h01 : 7'h0);
         wb(1, REG_CONTROL, 2);
         tick(3);
         check(o_fault_out_n_oe, 0);
         tick(20);
         check(o_gate_hi[0], 1);
      end
      rnd = lfsr(rnd);
      w = rnd[1:0];
      warn[w] <= 1'b1;
      watch(40);
      check(hi_cnt >= 15 && hi_cnt <= 25 && edges >= 4, 1);
      check(o_gate_hi, 3'h1);
      wb(0, REG_STATUS, 0);
      check(rd[3:0], 4'h1 << w);
      temp <= rnd[7:4] | 4'h1;
      tick(2);
      watch(20);
      check(hi_cnt, 0);
      wb(0, REG_STATUS, 0);
      check(rd[7:0], {rnd[7:4] | 4'h1, 4'h1 << w});
      temp <= 4'h0;
      warn[w] <= 1'b0;
      tick(3);
      wb(0, REG_STATUS, 0);
      check(rd[7:0], 0);
      warn[w] <= 1'b1;
      tick(4);
      check(o_fault_out_n_oe, 1);
      f = rnd[9:8];
      fault[f] <= 1'b1;
      tick(2);
      fault <= 4'h0;
      watch(30);
      check(hi_cnt, 30);
      check({o_gate_hi, o_gate_lo}, 0);
      wb(0, REG_STATUS, 0);
      check(rd[ST_FAULT_BIT], 1);
      check({o_fault_out_n, rd[ST_PIN_BIT]}, 0);
      wb(0, REG_ERRTYPE, 0);
      check(rd[11:8], 4'h1 << f);
      warn <= 4'h0;
      wb(1, REG_CONTROL, 2);
      tick(3);
      check(o_fault_out_n_oe, 0);
      wb(0, REG_STATUS, 0);
      check(rd[ST_FAULT_BIT], 0);
      wb(0, REG_CONTROL, 0);
      check(rd[CT_CLEAR_BIT], 0);
      fault[f] <= 1'b1;
      tick(2);
      fault <= 4'h0;
      tick(3);
      i_gate_en <= 1'b0;
      tick(2);
      i_gate_en <= 1'b1;
      tick(4);
      check(o_fault_out_n_oe, 0);
      tick(20);
      check(o_gate_hi[0], 1);
      for (int k = 0; k < 3; k++)
      begin
         i_vreg_in_range <= (k != 0);
         i_wdog_fault <= (k == 1);
         i_regulator_undervoltage <= (k == 2);
         tick(pg_len[k]);
         i_vreg_in_range <= 1'b1;
         i_wdog_fault <= 1'b0;
         i_regulator_undervoltage <= 1'b0;
         n = 0;
         while (o_power_good_out !== 1'b1 && n < 100)
         begin
            tick(1);
            n++;
         end
         lo_b = (pg_len[k] > PULSE) ? pg_len[k] : PULSE;
         check(pg_len[k] + n >= lo_b && pg_len[k] + n <= lo_b + 6, 1);
         tick(5);
      end
      print_verdict();
   end
endmodule

bind gdfp_top gdfp_props #(.WARN_N(WARN_N), .FAULT_N(FAULT_N), .P_PULSE_CYC(P_PULSE_CYC)) u_props
(
   .*
);

// [src/gdfp_pkg.sv]
// Constants shared by the gate driver fault protection block
package gdfp_pkg;
   // ********
   // Register indexes (byte address is four times index)
   // ********
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_ERRTYPE = 4'h2;
   localparam logic [3:0] REG_TIMING = 4'h7;
   localparam logic [3:0] REG_CONTROL = 4'h9;
   localparam logic [3:0] REG_OCP = 4'hc;
   localparam int ADR_LSB = 2;
   localparam int ADR_W = 8;

   // ********
   // Field positions
   // ********
   localparam int ST_WARN_LSB = 0;
   localparam int ST_TEMP_LSB = 4;
   localparam int ST_PGOOD_BIT = 8;
   localparam int ST_PIN_BIT = 9;
   localparam int ST_FAULT_BIT = 10;
   localparam int ET_OC_LSB = 0;
   localparam int ET_OCLAT_BIT = 6;
   localparam int ET_FLT_LSB = 8;
   localparam int TM_DEAD_LSB = 4;
   localparam int TM_BLANK_LSB = 2;
   localparam int TM_DEGL_LSB = 0;
   localparam int CT_CLEAR_BIT = 1;
   localparam int OC_THR_LSB = 3;
   localparam int OC_MODE_LSB = 0;

   // ********
   // Reset values
   // ********
   localparam logic [2:0] RST_DEAD = 3'h0;
   localparam logic [1:0] RST_BLANK = 2'h1;
   localparam logic [1:0] RST_DEGL = 2'h1;
   localparam logic [4:0] RST_THR = 5'h09;

   // Overcurrent response select encodings
   localparam logic [2:0] OCM_LATCH = 3'h0;
   localparam logic [2:0] OCM_REPORT = 3'h1;

   // ********
   // Timing
   // ********
   localparam int CLK_NS = 10;
   localparam int DEAD_STEP_NS = 40;
   localparam int BLANK_STEP_NS = 500;
   localparam int DEGL_STEP_NS = 1000;
   localparam int PULSE_US = 56;
   localparam int DEAD_STEP_CYC = (DEAD_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEGL_STEP_CYC = (DEGL_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = PULSE_US * 1000 / CLK_NS;
   localparam int CNT_W = 10;

   typedef enum logic [1:0] {PG_OK, PG_PULSE, PG_RECHECK} gdfp_pg_t;
endpackage

// [src/gdfp_top.sv]
// Fault classification, dead time, overcurrent and power-good logic
`timescale 1ns/10ps

// How it works
// - Power-good low 56 us, then until recovered
// - Warnings alone never touch gate drive
// - Warning sets status, toggles fault pin 56/56
// - Status read stops toggling, bit follows condition
// - Acknowledged warning rearms only after clearing
// - Fault shuts drive, holds pin, sets bits
// - Faults stay latched until recovery sequence
// - Fault overrides warning toggling
// - Fault forces all gate outputs off
// - Clear-faults bit self clears, pin released
// - Temperature flags only follow condition
// - Watchdog and regulator faults drive power-good
// - Opposite FET must reach cutoff first
// - Programmable dead time after handshake
// - Overcurrent threshold writable while running
// - Blank comparators after commanded turn-on
// - Deglitch comparator trips before reporting
// - Dead time and blanking run overlapped
// - Three overcurrent response modes selectable
// - Latched mode shuts all gates, reports FET
// - Report mode keeps switching; disabled ignores
module gdfp_top
#(
   parameter int WARN_N = 4,
   parameter int FAULT_N = 4,
   parameter int TEMP_N = 4,
   parameter int P_PULSE_CYC = gdfp_pkg::PULSE_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [gdfp_pkg::ADR_W-1:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_gate_en,
   input wire logic [2:0] i_gate_cmd_hi,
   input wire logic [2:0] i_gate_cmd_lo,
   input wire logic [5:0] i_vgs_off,
   input wire logic [5:0] i_oc_trip,
   input wire logic [WARN_N-1:0] i_warn_cond,
   input wire logic [FAULT_N-1:0] i_fault_cond,
   input wire logic [TEMP_N-1:0] i_temperature_flag,
   input wire logic i_vreg_in_range,
   input wire logic i_regulator_undervoltage,
   input wire logic i_wdog_fault,
   input wire logic i_fault_out_n,
   output logic o_fault_out_n,
   output logic o_fault_out_n_oe,
   output logic o_power_good_out,
   output logic [2:0] o_gate_hi,
   output logic [2:0] o_gate_lo,
   output logic [4:0] o_drain_source_threshold
);
   import gdfp_pkg::*;

   // ********
   // Elaboration checks
   // ********
   generate
      if (WARN_N < 1 || WARN_N > 4 || TEMP_N < 1 || TEMP_N > 4)
      begin : g_bad_width
         $error("warning and temperature inputs must number 1 to 4");
      end
      if (FAULT_N < 1 || FAULT_N > 8 || P_PULSE_CYC < 2 || P_PULSE_CYC > 65535)
      begin : g_bad_count
         $error("fault input count or pulse length out of range");
      end
   endgenerate

   // ********
   // Register bus
   // ********
   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic acc;
   logic wr;
   logic rd;
   logic [3:0] idx;
   logic [2:0] dead_sel_q;
   logic [1:0] blank_sel_q;
   logic [1:0] degl_sel_q;
   logic [4:0] thr_q;
   logic [2:0] mode_q;
   logic clr_q;
   logic [WARN_N-1:0] wack_q;
   logic [5:0] oc_stat_q;
   logic oc_lat_q;
   logic oc_tog_q;
   logic [FAULT_N-1:0] flt_q;
   logic en_prev_q;
   logic [5:0] gate_q;
   logic [5:0] cmd_prev_q;
   logic [5:0] oc_evt;
   logic [CNT_W-1:0] dead_cnt_q [6];
   logic [CNT_W-1:0] blank_cnt_q [6];
   logic [CNT_W-1:0] degl_cnt_q [6];
   logic [15:0] tog_cnt_q;
   logic tog_phase_q;
   logic oe_q;
   logic [15:0] pg_cnt_q;
   gdfp_pg_t pg_state_q;
   logic pg_q;

   assign acc = i_wb_cyc & i_wb_stb & ~ack_q;
   assign wr = acc & i_wb_we;
   assign rd = acc & ~i_wb_we;
   assign idx = i_wb_adr[ADR_LSB +: 4];

   // Answer one cycle after the request, drop ack the cycle after
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end
      else if (i_ce)
      begin
         ack_q <= acc;
         rdat_q <= rd ? rdat_d : 32'h0;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // Unmapped addresses answer with zero and ignore writes
   always_comb
   begin
      rdat_d = 32'h0;
      unique case (idx)
         REG_STATUS:
         begin
            rdat_d[ST_WARN_LSB +: WARN_N] = i_warn_cond;
            rdat_d[ST_TEMP_LSB +: TEMP_N] = i_temperature_flag;
            rdat_d[ST_PGOOD_BIT] = pg_q;
            rdat_d[ST_PIN_BIT] = i_fault_out_n;
            rdat_d[ST_FAULT_BIT] = (|flt_q) | oc_lat_q;
         end
         REG_ERRTYPE:
         begin
            rdat_d[ET_OC_LSB +: 6] = oc_stat_q;
            rdat_d[ET_OCLAT_BIT] = oc_lat_q;
            rdat_d[ET_FLT_LSB +: FAULT_N] = flt_q;
         end
         REG_TIMING:
         begin
            rdat_d[TM_DEAD_LSB +: 3] = dead_sel_q;
            rdat_d[TM_BLANK_LSB +: 2] = blank_sel_q;
            rdat_d[TM_DEGL_LSB +: 2] = degl_sel_q;
         end
         REG_CONTROL: rdat_d[CT_CLEAR_BIT] = clr_q;
         REG_OCP:
         begin
            rdat_d[OC_THR_LSB +: 5] = thr_q;
            rdat_d[OC_MODE_LSB +: 3] = mode_q;
         end
         default: rdat_d = 32'h0;
      endcase
   end

   // ********
   // Configuration registers
   // ********
   // Threshold has no lock: it may change while the bridge switches
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         dead_sel_q <= RST_DEAD;
         blank_sel_q <= RST_BLANK;
         degl_sel_q <= RST_DEGL;
         thr_q <= RST_THR;
         mode_q <= OCM_LATCH;
         o_drain_source_threshold <= RST_THR;
      end
      else if (i_ce)
      begin
         if (wr && idx == REG_TIMING && i_wb_sel[0])
         begin
            dead_sel_q <= i_wb_dat[TM_DEAD_LSB +: 3];
            blank_sel_q <= i_wb_dat[TM_BLANK_LSB +: 2];
            degl_sel_q <= i_wb_dat[TM_DEGL_LSB +: 2];
         end
         if (wr && idx == REG_OCP && i_wb_sel[0])
         begin
            thr_q <= i_wb_dat[OC_THR_LSB +: 5];
            mode_q <= i_wb_dat[OC_MODE_LSB +: 3];
         end
         o_drain_source_threshold <= thr_q;
      end
   end

   // ********
   // Fault latching and recovery
   // ********
   logic clr_req;
   logic fault_any;
   logic shut;
   logic lat_mode;
   logic rep_mode;

   assign clr_req = clr_q | (en_prev_q & ~i_gate_en);
   assign fault_any = (|flt_q) | oc_lat_q;
   assign shut = fault_any | ~i_gate_en;
   assign lat_mode = (mode_q == OCM_LATCH);
   assign rep_mode = (mode_q == OCM_REPORT);

   // A cause still present re-latches, so clearing only sticks once removed
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         flt_q <= '0;
         oc_lat_q <= 1'b0;
         clr_q <= 1'b0;
         en_prev_q <= 1'b0;
      end
      else if (i_ce)
      begin
         flt_q <= i_fault_cond | (flt_q & ~{FAULT_N{clr_req}});
         oc_lat_q <= (lat_mode & (|oc_evt)) | (oc_lat_q & ~clr_req);
         // Self clears the cycle after the clear has been applied
         clr_q <= wr && idx == REG_CONTROL && i_wb_sel[0] && i_wb_dat[CT_CLEAR_BIT];
         en_prev_q <= i_gate_en;
      end
   end

   // ********
   // Warnings and overcurrent reporting
   // ********
   logic rd_stat;
   logic rd_err;
   logic warn_active;

   assign rd_stat = rd && idx == REG_STATUS;
   assign rd_err = rd && idx == REG_ERRTYPE;
   assign warn_active = (|(i_warn_cond & ~wack_q)) | oc_tog_q;

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wack_q <= '0;
         oc_stat_q <= 6'h0;
         oc_tog_q <= 1'b0;
      end
      else if (i_ce)
      begin
         // Acknowledge holds until the condition goes away
         wack_q <= i_warn_cond & (wack_q | {WARN_N{rd_stat}});
         // New events win over the clearing read or fault clear
         oc_stat_q <= ((lat_mode | rep_mode) ? oc_evt : 6'h0)
            | (oc_stat_q & ~{6{rd_err & ~oc_lat_q | clr_req}});
         oc_tog_q <= (rep_mode & (|oc_evt)) | (oc_tog_q & ~rd_err);
      end
   end

   // ********
   // Fault pin
   // ********
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         tog_cnt_q <= 16'h0;
         tog_phase_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (i_ce)
      begin
         if (fault_any || !warn_active)
         begin
            tog_cnt_q <= 16'h0;
            tog_phase_q <= 1'b0;
         end
         else if (tog_cnt_q == 16'(P_PULSE_CYC - 1))
         begin
            tog_cnt_q <= 16'h0;
            tog_phase_q <= ~tog_phase_q;
         end
         else
         begin
            tog_cnt_q <= tog_cnt_q + 16'h1;
         end
         // Fault holds the pin low whatever the warning phase
         oe_q <= fault_any | (warn_active & ~tog_phase_q);
      end
   end

   assign o_fault_out_n = 1'b0;
   assign o_fault_out_n_oe = oe_q;

   // ********
   // Gate path: handshake, dead time, blanking, deglitch
   // ********
   logic [5:0] cmd6;
   logic [CNT_W-1:0] dead_len;
   logic [CNT_W-1:0] blank_len;
   logic [CNT_W-1:0] degl_len;

   assign cmd6 = {i_gate_cmd_lo, i_gate_cmd_hi};
   assign dead_len = CNT_W'((dead_sel_q + 4'h1) * DEAD_STEP_CYC);
   assign blank_len = CNT_W'((blank_sel_q + 3'h1) * BLANK_STEP_CYC);
   assign degl_len = CNT_W'((degl_sel_q + 3'h1) * DEGL_STEP_CYC);

   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_fet
         localparam int OPP = (g + 3) % 6;
         logic hs_ok;
         logic mon;
         // Opposite command must be idle, its gate off and its VGS at cutoff
         assign hs_ok = cmd6[g] & ~cmd6[OPP] & ~gate_q[OPP] & i_vgs_off[OPP] & ~shut;
         assign mon = gate_q[g] & cmd6[g] & (blank_cnt_q[g] == '0);
         assign oc_evt[g] = mon & i_oc_trip[g] & (degl_cnt_q[g] == degl_len - CNT_W'(1));

         always_ff @(posedge i_mclk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               dead_cnt_q[g] <= '0;
               blank_cnt_q[g] <= '0;
               degl_cnt_q[g] <= '0;
               cmd_prev_q[g] <= 1'b0;
               gate_q[g] <= 1'b0;
            end
            else if (i_ce)
            begin
               cmd_prev_q[g] <= cmd6[g];
               // Dead time counts only after the handshake has passed
               if (!hs_ok)
               begin
                  dead_cnt_q[g] <= dead_len;
               end
               else if (dead_cnt_q[g] != '0)
               begin
                  dead_cnt_q[g] <= dead_cnt_q[g] - CNT_W'(1);
               end
               gate_q[g] <= hs_ok & (dead_cnt_q[g] == '0);
               // Blanking starts at the command, so it overlaps the dead time
               if (cmd6[g] && !cmd_prev_q[g])
               begin
                  blank_cnt_q[g] <= blank_len;
               end
               else if (blank_cnt_q[g] != '0)
               begin
                  blank_cnt_q[g] <= blank_cnt_q[g] - CNT_W'(1);
               end
               if (!(mon && i_oc_trip[g]))
               begin
                  degl_cnt_q[g] <= '0;
               end
               else if (degl_cnt_q[g] != degl_len)
               begin
                  degl_cnt_q[g] <= degl_cnt_q[g] + CNT_W'(1);
               end
            end
         end
      end
   endgenerate

   // Warnings and report-only events never reach this path
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_gate_hi <= 3'h0;
         o_gate_lo <= 3'h0;
      end
      else if (i_ce)
      begin
         o_gate_hi <= gate_q[2:0] & ~{3{shut}};
         o_gate_lo <= gate_q[5:3] & ~{3{shut}};
      end
   end

   // ********
   // Power good sequencing
   // ********
   logic pg_trouble;

   assign pg_trouble = ~i_vreg_in_range | i_regulator_undervoltage | i_wdog_fault;

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pg_state_q <= PG_RECHECK;
         pg_cnt_q <= 16'h0;
         pg_q <= 1'b0;
      end
      else if (i_ce)
      begin
         unique case (pg_state_q)
            PG_OK:
            begin
               pg_cnt_q <= 16'h0;
               if (pg_trouble)
               begin
                  pg_state_q <= PG_PULSE;
                  pg_q <= 1'b0;
               end
            end
            PG_PULSE:
            begin
               pg_q <= 1'b0;
               if (pg_cnt_q == 16'(P_PULSE_CYC - 1))
               begin
                  pg_cnt_q <= 16'h0;
                  pg_state_q <= PG_RECHECK;
               end
               else
               begin
                  pg_cnt_q <= pg_cnt_q + 16'h1;
               end
            end
            PG_RECHECK:
            begin
               // A watchdog pulse here is only a recheck, not a new pulse
               if (i_vreg_in_range && !i_regulator_undervoltage)
               begin
                  pg_state_q <= PG_OK;
                  pg_q <= 1'b1;
               end
            end
         endcase
      end
   end

   assign o_power_good_out = pg_q;
endmodule
